//--- src/sbg_pkg.sv
// Purpose: shared constants and types for the storage bridge gpio block
// Assumes: axi4-lite register access, 32-bit data
// Notes: byte offsets are word aligned
package sbg_pkg;
   localparam int NPIN = 8;
   localparam logic [7:0] OFS_DIR = 8'h00;
   localparam logic [7:0] OFS_OUT = 8'h04;
   localparam logic [7:0] OFS_IN = 8'h08;
   localparam logic [7:0] OFS_CTRL = 8'h0C;
   localparam logic [7:0] OFS_STAT = 8'h10;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFS_IRQ_EN = 8'h18;
   localparam logic [7:0] OFS_IRQ_CLR = 8'h1C;
   localparam logic [7:0] OFS_EE_CMD = 8'h20;
   localparam logic [7:0] OFS_EE_DATA = 8'h24;
   // pin indices (card_type_strap_pin..8 map to bits 0..7)
   localparam int PIN_STRAP = 0;
   localparam int PIN_PWR = 1;
   localparam int PIN_DRST = 2;
   localparam int PIN_EE_CS = 3;
   localparam int PIN_EE_SK = 4;
   localparam int PIN_EE_DI = 5;
   localparam int PIN_EE_DO = 6;
   localparam int PIN_DET = 7;
   localparam logic [7:0] DIR_RESET = 8'h00;
   localparam logic [7:0] OUT_RESET = 8'h00;
   localparam logic [7:0] EE_PIN_MASK = 8'h78;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // eeprom serial clock half period in aclk cycles
   localparam int EE_HALF = 4;
   localparam int EE_BITS = 16;
   localparam int N_EVT = 4;
   // event bits: card inserted, card removed, strap sampled, eeprom done
   localparam int EVT_INS = 0;
   localparam int EVT_REM = 1;
   localparam int EVT_STRAP = 2;
   localparam int EVT_EE = 3;
   typedef struct packed {
      logic [7:0] o;
      logic [7:0] oe;
   } sbg_pins_t;
   typedef enum logic [1:0] {
      SBG_ATA,
      SBG_CARD
   } sbg_mode_t;
endpackage

//--- src/sbg_ee_shift.sv
// Purpose: serial eeprom shifter on four gpio pins
// Assumes: microwire style chip select, clock, data in, data out
// Notes: shifts EE_BITS bits msb first, captures reply bits
`timescale 1ns/100ps
`default_nettype none
module sbg_ee_shift
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic start,
   input wire logic [15:0] cmd,
   input wire logic din,
   output logic busy,
   output logic done,
   output logic cs,
   output logic sk,
   output logic dout,
   output logic [15:0] rdata
);
   logic [3:0] tick_q;
   logic [4:0] cnt_q;
   logic [15:0] sh_q;
   logic tick;
   assign tick = (tick_q == 4'(sbg_pkg::EE_HALF - 1));
   assign cs = busy;
   assign dout = sh_q[15];
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tick_q <= '0;
         cnt_q <= '0;
         sh_q <= '0;
         busy <= 1'b0;
         sk <= 1'b0;
         done <= 1'b0;
         rdata <= '0;
      end
      else
      begin
         done <= 1'b0;
         if (!busy)
         begin
            tick_q <= '0;
            if (start)
            begin
               busy <= 1'b1;
               sh_q <= cmd;
               cnt_q <= '0;
            end
         end
         else if (tick)
         begin
            tick_q <= '0;
            sk <= ~sk;
            if (sk)
            begin
               sh_q <= {sh_q[14:0], 1'b0};
               cnt_q <= cnt_q + 5'h01;
               if (cnt_q == 5'(sbg_pkg::EE_BITS - 1))
               begin
                  busy <= 1'b0;
                  done <= 1'b1;
               end
            end
            else
               rdata <= {rdata[14:0], din};
         end
         else
            tick_q <= tick_q + 4'h1;
      end
   end
endmodule
`default_nettype wire

//--- src/sbg_gpio_top.sv
// Purpose: gpio control of a usb storage bridge, axi4-lite registers
// Assumes: pins synchronous to aclk; vendor requests arrive as
//          register writes from the endpoint zero engine
// Notes: pin pads resolved outside from o/oe
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - three requests: direction, read, write levels
// - eight pins host controllable except power pin in card mode, drive reset pin when set, eeprom select, clock and data in pins while busy
// - requests carried on control endpoint zero
// - strap sampled at bus reset, high means card
// - card power off during suspend
// - drive reset pin drives attached unit reset
// - card used in ide register mode only
// - pins four to seven form eeprom link
// - card detect is active low
module sbg_gpio_top
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic usb_bus_reset,
   input wire logic usb_suspend,
   input wire logic [7:0] gpio_in,
   output logic [7:0] gpio_out,
   output logic [7:0] gpio_oe,
   output logic card_mode,
   output logic card_present,
   output logic irq
);
   logic [7:0] dir_q;
   logic [7:0] out_q;
   logic [7:0] in_q;
   logic card_q;
   logic det_q;
   logic drst_q;
   logic pwr_en_q;
   logic [3:0] ist_q;
   logic [3:0] ien_q;
   logic [15:0] ee_cmd_q;
   logic ee_go_q;
   logic [7:0] aw_q;
   logic [31:0] w_q;
   logic [3:0] ws_q;
   logic aw_have_q;
   logic w_have_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic [1:0] bresp_q;
   logic bvalid_q;
   logic rvalid_q;
   logic ee_busy;
   logic ee_done;
   logic ee_cs;
   logic ee_sk;
   logic ee_do;
   logic [15:0] ee_rdata;
   sbg_pkg::sbg_pins_t pins;

   // write address/data taken in either order, response after both
   wire aw_take = s_axi_awvalid && !aw_have_q;
   wire w_take = s_axi_wvalid && !w_have_q;
   wire wr_hi = (s_axi_awaddr[31:8] != 24'h000000) && !aw_have_q;
   // out-of-range address never reaches a register
   wire [7:0] aw_eff = aw_have_q ? aw_q
      : (wr_hi ? 8'hFF : s_axi_awaddr[7:0]);
   wire [31:0] w_eff = w_have_q ? w_q : s_axi_wdata;
   wire [3:0] ws_eff = w_have_q ? ws_q : s_axi_wstrb;
   wire wr_go = (aw_have_q || aw_take) && (w_have_q || w_take)
      && !bvalid_q;
   wire wr_lane = ws_eff[0];
   wire wr_dir = wr_go && wr_lane && aw_eff == sbg_pkg::OFS_DIR;
   wire wr_out = wr_go && wr_lane && aw_eff == sbg_pkg::OFS_OUT;
   wire wr_ctrl = wr_go && wr_lane && aw_eff == sbg_pkg::OFS_CTRL;
   wire wr_ien = wr_go && wr_lane && aw_eff == sbg_pkg::OFS_IRQ_EN;
   wire wr_iclr = wr_go && wr_lane && aw_eff == sbg_pkg::OFS_IRQ_CLR;
   wire wr_ee = wr_go && ws_eff[1:0] == 2'h3
      && aw_eff == sbg_pkg::OFS_EE_CMD;
   wire wr_map = !wr_hi && (aw_eff == sbg_pkg::OFS_DIR
      || aw_eff == sbg_pkg::OFS_OUT || aw_eff == sbg_pkg::OFS_CTRL
      || aw_eff == sbg_pkg::OFS_IRQ_EN || aw_eff == sbg_pkg::OFS_IRQ_CLR
      || aw_eff == sbg_pkg::OFS_EE_CMD);

   assign s_axi_awready = !aw_have_q;
   assign s_axi_wready = !w_have_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   wire rd_go = s_axi_arvalid && !rvalid_q;
   wire [7:0] ra = s_axi_araddr[7:0];
   wire ra_hi = s_axi_araddr[31:8] != 24'h000000;
   // read pin levels, status and eeprom reply
   wire [31:0] rd_mux =
      ra == sbg_pkg::OFS_DIR ? {24'h000000, dir_q} :
      ra == sbg_pkg::OFS_OUT ? {24'h000000, out_q} :
      ra == sbg_pkg::OFS_IN ? {24'h000000, in_q} :
      ra == sbg_pkg::OFS_CTRL ? {30'h00000000, pwr_en_q, drst_q} :
      ra == sbg_pkg::OFS_STAT ? {29'h00000000, ee_busy, det_q, card_q} :
      ra == sbg_pkg::OFS_IRQ_STAT ? {28'h0000000, ist_q} :
      ra == sbg_pkg::OFS_IRQ_EN ? {28'h0000000, ien_q} :
      ra == sbg_pkg::OFS_EE_DATA ? {16'h0000, ee_rdata} : 32'h00000000;
   wire ra_ok = !ra_hi && (ra == sbg_pkg::OFS_DIR
      || ra == sbg_pkg::OFS_OUT || ra == sbg_pkg::OFS_IN
      || ra == sbg_pkg::OFS_CTRL || ra == sbg_pkg::OFS_STAT
      || ra == sbg_pkg::OFS_IRQ_STAT || ra == sbg_pkg::OFS_IRQ_EN
      || ra == sbg_pkg::OFS_EE_DATA || ra == sbg_pkg::OFS_IRQ_CLR);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_q <= '0;
         w_q <= '0;
         ws_q <= '0;
         bvalid_q <= 1'b0;
         bresp_q <= sbg_pkg::RESP_OKAY;
      end
      else
      begin
         if (wr_go)
         begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_map ? sbg_pkg::RESP_OKAY : sbg_pkg::RESP_SLVERR;
         end
         else
         begin
            if (aw_take)
            begin
               aw_have_q <= 1'b1;
               aw_q <= wr_hi ? 8'hFF : s_axi_awaddr[7:0];
            end
            if (w_take)
            begin
               w_have_q <= 1'b1;
               w_q <= s_axi_wdata;
               ws_q <= s_axi_wstrb;
            end
            if (bvalid_q && s_axi_bready)
               bvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= sbg_pkg::RESP_OKAY;
      end
      else if (rd_go)
      begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_mux;
         rresp_q <= ra_ok ? sbg_pkg::RESP_OKAY : sbg_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
         rvalid_q <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         dir_q <= sbg_pkg::DIR_RESET;
         out_q <= sbg_pkg::OUT_RESET;
         drst_q <= 1'b0;
         pwr_en_q <= 1'b0;
         ien_q <= '0;
         ee_cmd_q <= '0;
         ee_go_q <= 1'b0;
      end
      else
      begin
         ee_go_q <= wr_ee && !ee_busy;
         if (wr_dir)
            dir_q <= w_eff[7:0];
         if (wr_out)
            out_q <= w_eff[7:0];
         if (wr_ctrl)
         begin
            drst_q <= w_eff[0];
            pwr_en_q <= w_eff[1];
         end
         if (wr_ien)
            ien_q <= w_eff[3:0];
         if (wr_ee && !ee_busy)
            ee_cmd_q <= w_eff[15:0];
      end
   end

   // strap sampled while bus reset is held
   wire det_now = !gpio_in[sbg_pkg::PIN_DET];
   wire [3:0] evt = {ee_done, usb_bus_reset, det_q && !det_now,
      !det_q && det_now};
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         in_q <= '0;
         det_q <= 1'b0;
         card_q <= 1'b0;
         ist_q <= '0;
      end
      else
      begin
         in_q <= gpio_in;
         det_q <= det_now;
         if (usb_bus_reset)
            card_q <= gpio_in[sbg_pkg::PIN_STRAP];
         // set wins over clear
         ist_q <= (ist_q & ~(wr_iclr ? w_eff[3:0] : 4'h0)) | evt;
      end
   end

   assign irq = |(ist_q & ien_q);
   assign card_mode = card_q;
   assign card_present = det_q;

   // eeprom link on pins four to seven
   // ids read back from the eeprom by the host
   sbg_ee_shift u_ee
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(ee_go_q),
      .cmd(ee_cmd_q),
      .din(gpio_in[sbg_pkg::PIN_EE_DO]),
      .busy(ee_busy),
      .done(ee_done),
      .cs(ee_cs),
      .sk(ee_sk),
      .dout(ee_do),
      .rdata(ee_rdata)
   );

   // pin driven straight from host registers
   // writes come from the endpoint zero engine
   // drive reset, power and eeprom pins only; no card mode select
   genvar i;
   generate
      for (i = 0; i < sbg_pkg::NPIN; i++)
      begin : g_pin
         always_comb
         begin
            pins.o[i] = out_q[i];
            pins.oe[i] = dir_q[i];
            if (i == sbg_pkg::PIN_PWR && card_q)
            begin
               pins.o[i] = pwr_en_q && !usb_suspend;
               pins.oe[i] = 1'b1;
            end
            if (i == sbg_pkg::PIN_DRST && drst_q)
            begin
               pins.o[i] = 1'b0;
               pins.oe[i] = 1'b1;
            end
            if (ee_busy && i == sbg_pkg::PIN_EE_CS)
            begin
               pins.o[i] = ee_cs;
               pins.oe[i] = 1'b1;
            end
            if (ee_busy && i == sbg_pkg::PIN_EE_SK)
            begin
               pins.o[i] = ee_sk;
               pins.oe[i] = 1'b1;
            end
            if (ee_busy && i == sbg_pkg::PIN_EE_DI)
            begin
               pins.o[i] = ee_do;
               pins.oe[i] = 1'b1;
            end
         end
      end
   endgenerate
   assign gpio_out = pins.o;
   assign gpio_oe = pins.oe;

   // power pin low during suspend in card mode
   a_pwr_suspend: assert property (@(posedge aclk) disable iff (!aresetn)
      (usb_suspend && card_q) |-> !gpio_out[sbg_pkg::PIN_PWR])
      else $error("card power on in suspend");
   a_strap_sample: assert property (@(posedge aclk) disable iff (!aresetn)
      usb_bus_reset |=> card_q == $past(gpio_in[sbg_pkg::PIN_STRAP]))
      else $error("strap not sampled");
   a_detect_low: assert property (@(posedge aclk) disable iff (!aresetn)
      1'b1 |=> card_present == !$past(gpio_in[sbg_pkg::PIN_DET]))
      else $error("card detect polarity");
   a_drst_drive: assert property (@(posedge aclk) disable iff (!aresetn)
      drst_q |-> gpio_oe[sbg_pkg::PIN_DRST]
      && !gpio_out[sbg_pkg::PIN_DRST])
      else $error("drive reset not driven");
   a_dir_write: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_dir |=> dir_q == $past(w_eff[7:0]))
      else $error("direction not written");
   a_pin_follow: assert property (@(posedge aclk) disable iff (!aresetn)
      (!ee_busy && !drst_q && !card_q) |-> gpio_oe == dir_q)
      else $error("pin enable differs from direction");
   a_reset_input: assert property (@(posedge aclk)
      !aresetn |=> gpio_oe == 8'h00)
      else $error("pins driven after reset");
   a_ee_pins: assert property (@(posedge aclk) disable iff (!aresetn)
      ee_busy |-> gpio_oe[sbg_pkg::PIN_EE_CS]
      && gpio_out[sbg_pkg::PIN_EE_CS])
      else $error("eeprom select not driven");
   a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(ist_q[sbg_pkg::EVT_STRAP]) && ien_q[sbg_pkg::EVT_STRAP]
      |-> irq)
      else $error("interrupt missing");
endmodule
`default_nettype wire

//--- tb/sbg_board.sv
// Purpose: board model on the gpio pins of the storage bridge
// Assumes: external drive given by ext, microwire eeprom on pins 3..6
// Notes: released data out line toggles so stale values never match
`timescale 1ns/100ps
`default_nettype none
module sbg_board
#(
   // reply word is arbitrary, stands in for the stored ids
   parameter logic [15:0] REPLY = 16'h5AC3
)
(
   input wire logic aclk,
   input wire logic clr,
   input wire logic [7:0] pin_o,
   input wire logic [7:0] pin_oe,
   input wire logic [7:0] ext,
   output logic [7:0] pin_i,
   output var int sk_cnt,
   output var logic [15:0] cmd_q
);
   logic sk_q = 1'b0;
   logic tgl = 1'b0;
   logic [15:0] rep_q = REPLY;
   logic sel;
   assign sel = pin_oe[3] & pin_o[3];
   always_comb
   begin
      pin_i = (pin_oe & pin_o) | (~pin_oe & ext);
      if (!pin_oe[6])
         pin_i[6] = sel ? rep_q[15] : tgl;
   end
   always @(posedge aclk)
   begin
      tgl <= ~tgl;
      sk_q <= pin_o[4];
      if (clr)
      begin
         sk_cnt <= 0;
         cmd_q <= 16'h0;
         rep_q <= REPLY;
      end
      else if (sel && pin_o[4] && !sk_q)
      begin
         sk_cnt <= sk_cnt + 1;
         cmd_q <= {cmd_q[14:0], pin_o[5]};
         // next reply bit after the rising clock was seen
         rep_q <= {rep_q[14:0], 1'b0};
      end
   end
endmodule
`default_nettype wire

//--- tb/tb_sbg_gpio_top.sv
// Purpose: self-checking bench for the storage bridge gpio block
// Assumes: axi4-lite master tasks, board model on the pins
// Notes: expected values follow the register map of the package
`timescale 1ns/100ps
`default_nettype none
module tb_sbg_gpio_top;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic bus_rst = 1'b0, susp = 1'b0, clr = 1'b0;
   // strap pulled low, card detect pulled up
   logic [7:0] ext = 8'h80;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rres;
   logic [31:0] rdata, rdat;
   logic [7:0] pin_i, pout, poe;
   logic card_mode, card_present, irq;
   logic [15:0] ee_cmd;
   int sk_cnt;
   int miscompares = 0, n_compared = 0;
   logic [7:0] pat [4] = '{8'hA5, 8'h5A, 8'hFF, 8'h00};
   localparam logic [15:0] EE_REPLY = 16'h5AC3;

   always #50 aclk = ~aclk;

   sbg_gpio_top u_dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .usb_bus_reset(bus_rst), .usb_suspend(susp), .gpio_in(pin_i),
      .gpio_out(pout), .gpio_oe(poe), .card_mode(card_mode),
      .card_present(card_present), .irq(irq));

   sbg_board #(.REPLY(EE_REPLY)) u_board (.aclk(aclk), .clr(clr),
      .pin_o(pout), .pin_oe(poe),
      .ext(ext), .pin_i(pin_i), .sk_cnt(sk_cnt), .cmd_q(ee_cmd));

   task automatic step(input int n);
      repeat (n) @(posedge aclk);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s = 4'hF,
      input logic [1:0] er = sbg_pkg::RESP_OKAY);
      @(posedge aclk);
      awaddr <= {24'h0, a};
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk(32'(bresp), 32'(er));
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= {24'h0, a};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'b0;
      end
      while (rvalid !== 1'b1);
      rready <= 1'b0;
      rdat = rdata;
      rres = rresp;
   endtask

   task automatic finish_test;
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial
   begin
      step(4000);
      miscompares++;
      finish_test();
   end

   initial
   begin
      step(2);
      aresetn <= 1'b1;
      step(1);
      chk(32'(poe), 32'h0);
      rd(sbg_pkg::OFS_DIR);
      chk(rdat, 32'h0);
      // byte lane 0 off: write ignored
      wr(sbg_pkg::OFS_DIR, 32'hFF, 4'h0);
      chk(32'(poe), 32'h0);
      wr(sbg_pkg::OFS_DIR, 32'hFF);
      chk(32'(poe), 32'hFF);
      foreach (pat[i])
      begin
         wr(sbg_pkg::OFS_OUT, 32'(pat[i]));
         chk(32'(pout), 32'(pat[i]));
         rd(sbg_pkg::OFS_IN);
         chk(rdat, 32'(pat[i]));
      end
      wr(sbg_pkg::OFS_DIR, 32'h0);
      ext <= 8'hC3;
      step(3);
      rd(sbg_pkg::OFS_IN);
      chk(rdat & 32'hBF, 32'h83);
      ext <= 8'h80;
      wr(sbg_pkg::OFS_IRQ_CLR, 32'hF);
      wr(sbg_pkg::OFS_IRQ_EN, 32'h1);
      chk(32'(irq), 32'h0);
      ext <= 8'h00;
      step(3);
      chk(32'(card_present), 32'h1);
      chk(32'(irq), 32'h1);
      rd(sbg_pkg::OFS_STAT);
      chk(rdat & 32'h2, 32'h2);
      wr(sbg_pkg::OFS_IRQ_CLR, 32'h1);
      chk(32'(irq), 32'h0);
      ext <= 8'h80;
      step(3);
      chk(32'(card_present), 32'h0);
      chk(32'(irq), 32'h0);
      rd(sbg_pkg::OFS_IRQ_STAT);
      chk(rdat, 32'h2);
      wr(sbg_pkg::OFS_IRQ_EN, 32'h2);
      chk(32'(irq), 32'h1);
      wr(sbg_pkg::OFS_IRQ_CLR, 32'h2);
      chk(32'(irq), 32'h0);
      rd(sbg_pkg::OFS_IRQ_CLR);
      chk(rdat, 32'h0);
      // strap high at bus reset selects card mode
      ext <= 8'h81;
      bus_rst <= 1'b1;
      step(2);
      bus_rst <= 1'b0;
      step(2);
      chk(32'(card_mode), 32'h1);
      rd(sbg_pkg::OFS_STAT);
      chk(rdat & 32'h1, 32'h1);
      ext <= 8'h80;
      step(3);
      chk(32'(card_mode), 32'h1);
      wr(sbg_pkg::OFS_CTRL, 32'h2);
      chk(32'({poe[1], pout[1]}), 32'h3);
      susp <= 1'b1;
      step(2);
      chk(32'({poe[1], pout[1]}), 32'h2);
      susp <= 1'b0;
      wr(sbg_pkg::OFS_IRQ_CLR, 32'h4);
      wr(sbg_pkg::OFS_IRQ_EN, 32'h4);
      chk(32'(irq), 32'h0);
      bus_rst <= 1'b1;
      step(2);
      bus_rst <= 1'b0;
      step(2);
      chk(32'(card_mode), 32'h0);
      chk(32'(irq), 32'h1);
      rd(sbg_pkg::OFS_IRQ_STAT);
      chk(rdat & 32'h4, 32'h4);
      susp <= 1'b1;
      step(2);
      chk(32'(poe[1]), 32'h0);
      susp <= 1'b0;
      wr(sbg_pkg::OFS_CTRL, 32'h1);
      chk(32'({poe[2], pout[2]}), 32'h2);
      wr(sbg_pkg::OFS_CTRL, 32'h0);
      chk(32'(poe[2]), 32'h0);
      clr <= 1'b1;
      step(1);
      clr <= 1'b0;
      wr(sbg_pkg::OFS_EE_CMD, 32'hA53C, 4'h3);
      step(2);
      chk(32'(poe & sbg_pkg::EE_PIN_MASK), 32'h38);
      rd(sbg_pkg::OFS_STAT);
      chk(rdat & 32'h4, 32'h4);
      do
         rd(sbg_pkg::OFS_STAT);
      while (rdat[2] !== 1'b0);
      chk(32'(sk_cnt), 32'(sbg_pkg::EE_BITS));
      chk(32'(ee_cmd), 32'hA53C);
      rd(sbg_pkg::OFS_EE_DATA);
      chk(rdat, 32'(EE_REPLY));
      rd(sbg_pkg::OFS_IRQ_STAT);
      chk(rdat & 32'h8, 32'h8);
      chk(32'(poe & sbg_pkg::EE_PIN_MASK), 32'h0);
      wr(8'h40, 32'h1, 4'hF, sbg_pkg::RESP_SLVERR);
      rd(8'h40);
      chk(32'(rres), 32'(sbg_pkg::RESP_SLVERR));
      finish_test();
   end
endmodule
`default_nettype wire
